// File: core/ccrm_monitor.sv
// current channel result monitor: accumulator, comparator, over-range, result counter
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ccrm_monitor
	import ccrm_pkg::*;
#(
	parameter int OVR_CYC = OVR_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        arst_n_i,
	input  wire logic        res_valid_i,
	input  wire logic [15:0] res_data_i,
	input  wire logic        over_range_i,
	input  wire logic        vt_valid_i,
	input  wire logic [15:0] vt_data_i,
	input  wire logic [3:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	output logic             gnd_switch_o,
	output logic             irq_o
);
	import ccrm_pkg::*;

	logic [7:0]         cfg_r, cfg_nxt;
	logic [3:0]         sta_r, sta_nxt;
	logic signed [31:0] acc_r, acc_nxt;
	logic [15:0]        thr_r, thr_nxt;
	logic [7:0]         tlim_r, tlim_nxt;
	logic [7:0]         hits_r, hits_nxt;
	logic [15:0]        rlim_r, rlim_nxt;
	logic [15:0]        rcnt_r, rcnt_nxt;
	logic [15:0]        vt_r, vt_nxt;
	logic [31:0]        rdata_r, rdata_nxt;
	logic [1:0]         acc_mode, cmp_mode;
	logic signed [15:0] res_s;
	logic [15:0]        res_mag;
	logic               hit, ovr_expired, cfg_wr, sta_wr;
	logic signed [31:0] acc_sum;

	assign acc_mode = cfg_r[CFG_ACC_LO +: 2];
	assign cmp_mode = cfg_r[CFG_CMP_LO +: 2];
	assign res_s    = signed'(res_data_i);
	// magnitude of the two's complement result
	assign res_mag  = res_s[15] ? 16'(-res_s) : res_data_i;
	assign hit      = res_mag >= thr_r;
	assign cfg_wr   = reg_wr_i && (reg_addr_i == OFS_CONFIG);
	assign sta_wr   = reg_wr_i && (reg_addr_i == OFS_STATUS);
	assign acc_sum  = acc_r + 32'(res_s);

	ccrm_persist #(
		.CYCLES (OVR_CYC)
	) u_persist (
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.enable_i  (cfg_r[CFG_OVR_EN_BIT]),
		.level_i   (over_range_i),
		.expired_o (ovr_expired)
	);

	// register writes
	always_comb begin
		cfg_nxt  = cfg_r;
		thr_nxt  = thr_r;
		tlim_nxt = tlim_r;
		rlim_nxt = rlim_r;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				OFS_CONFIG:    cfg_nxt  = reg_wdata_i[7:0] & 8'hfd;
				OFS_THRESHOLD: thr_nxt  = reg_wdata_i[15:0];
				OFS_THR_LIMIT: tlim_nxt = reg_wdata_i[7:0];
				OFS_RES_LIMIT: rlim_nxt = reg_wdata_i[15:0];
				default:       cfg_nxt  = cfg_r;
			endcase
		end
	end

	// accumulator
	always_comb begin
		acc_nxt = acc_r;
		unique case (acc_mode)
			ACC_CLAMP: begin
				if (res_valid_i) begin
					acc_nxt = (acc_sum < 0) ? 32'sh0 : acc_sum;
				end
			end
			ACC_SIGNED: if (res_valid_i) acc_nxt = acc_sum;
			default: acc_nxt = 32'sh0;
		endcase
	end

	// comparator hit counter and result counter
	always_comb begin
		hits_nxt = hits_r;
		rcnt_nxt = rcnt_r;
		if (res_valid_i) begin
			unique case (cmp_mode)
				CMP_CNT_CLR, CMP_CNT_DEC: begin
					if (hit) begin
						hits_nxt = (hits_r == tlim_r) ? hits_r : hits_r + 8'h01;
					end else if (cmp_mode == CMP_CNT_CLR) begin
						hits_nxt = 8'h00;
					end else if (hits_r != 8'h00) begin
						hits_nxt = hits_r - 8'h01;
					end
				end
				default: hits_nxt = 8'h00;
			endcase
			if (cfg_r[CFG_RCNT_EN_BIT]) begin
				rcnt_nxt = (rcnt_r + 16'h0001 >= rlim_r) ? 16'h0000 : rcnt_r + 16'h0001;
			end
		end
		// reconfiguring restarts the result count
		if (cfg_wr) begin
			rcnt_nxt = 16'h0000;
		end
	end

	// status flags: hardware set wins over write-one-to-clear
	always_comb begin
		sta_nxt = sta_r;
		if (sta_wr) begin
			sta_nxt = sta_r & ~reg_wdata_i[3:0];
		end
		if (res_valid_i) begin
			if (!cfg_r[CFG_RCNT_EN_BIT] || (rcnt_r + 16'h0001 >= rlim_r)) begin
				sta_nxt[STA_CONV_BIT] = 1'b1;
			end
			if (cmp_mode == CMP_PLAIN && hit) begin
				sta_nxt[STA_CMP_BIT] = 1'b1;
			end
			// count modes flag at the limit
			if ((cmp_mode == CMP_CNT_CLR || cmp_mode == CMP_CNT_DEC) && hits_nxt == tlim_r
				&& hit) begin
				sta_nxt[STA_CMP_BIT] = 1'b1;
			end
		end
		if (ovr_expired) begin
			sta_nxt[STA_OVR_BIT] = 1'b1;
		end
		if (vt_valid_i) begin
			sta_nxt[STA_VT_BIT] = 1'b1;
		end
	end

	// latest voltage/temperature result overwrites the last
	always_comb begin
		vt_nxt = vt_valid_i ? vt_data_i : vt_r;
	end

	// read mux
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				OFS_CONFIG:    rdata_nxt = {24'h0, cfg_r};
				OFS_STATUS:    rdata_nxt = {28'h0, sta_r};
				OFS_ACC:       rdata_nxt = acc_r;
				OFS_THRESHOLD: rdata_nxt = {16'h0, thr_r};
				OFS_THR_LIMIT: rdata_nxt = {24'h0, tlim_r};
				OFS_THR_COUNT: rdata_nxt = {24'h0, hits_r};
				OFS_RES_LIMIT: rdata_nxt = {16'h0, rlim_r};
				OFS_RES_COUNT: rdata_nxt = {16'h0, rcnt_r};
				OFS_VT_RESULT: rdata_nxt = {16'h0, vt_r};
				default:       rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// state registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cfg_r   <= CONFIG_RST;
			sta_r   <= 4'h0;
			acc_r   <= 32'sh0;
			thr_r   <= THRESHOLD_RST;
			tlim_r  <= THR_LIMIT_RST;
			hits_r  <= 8'h00;
			rlim_r  <= RES_LIMIT_RST;
			rcnt_r  <= 16'h0000;
			vt_r    <= 16'h0000;
			rdata_r <= 32'h0000_0000;
		end else begin
			cfg_r   <= cfg_nxt;
			sta_r   <= sta_nxt;
			acc_r   <= acc_nxt;
			thr_r   <= thr_nxt;
			tlim_r  <= tlim_nxt;
			hits_r  <= hits_nxt;
			rlim_r  <= rlim_nxt;
			rcnt_r  <= rcnt_nxt;
			vt_r    <= vt_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata_o  = rdata_r;
	assign gnd_switch_o = cfg_r[CFG_GND_SW_BIT];
	assign irq_o        = |sta_r;

	// assertions
	// disabled accumulator stays zero
	a_acc_off_zero: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		acc_mode == ACC_OFF |=> acc_r == 32'sh0) else $error("accumulator not zero");
	a_acc_clamp_pos: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		acc_mode == ACC_CLAMP && res_valid_i |=> !acc_r[31]) else $error("clamp broken");
	a_acc_signed_add: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		acc_mode == ACC_SIGNED && res_valid_i && !cfg_wr |=>
		acc_r == $past(acc_r) + 32'($past(res_s))) else $error("signed sum wrong");
	a_cmp_off_quiet: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cmp_mode == CMP_OFF && !sta_r[STA_CMP_BIT] && !cfg_wr |=> !sta_r[STA_CMP_BIT])
		else $error("comparator flagged while off");
	a_cmp_plain_hit: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cmp_mode == CMP_PLAIN && res_valid_i && hit |=> sta_r[STA_CMP_BIT])
		else $error("plain hit missed");
	a_cnt_clr_miss: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cmp_mode == CMP_CNT_CLR && res_valid_i && !hit && !cfg_wr |=> hits_r == 8'h00)
		else $error("hit counter not cleared");
	a_cnt_dec_miss: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cmp_mode == CMP_CNT_DEC && res_valid_i && !hit && hits_r != 8'h00 && !cfg_wr
		|=> hits_r == $past(hits_r) - 8'h01) else $error("hit counter not decremented");
	a_rcnt_wraps: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cfg_r[CFG_RCNT_EN_BIT] && res_valid_i && rcnt_r + 16'h0001 >= rlim_r
		|=> rcnt_r == 16'h0000) else $error("result count did not wrap");
	a_ovr_flag_set: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		ovr_expired |=> sta_r[STA_OVR_BIT]) else $error("over-range flag missed");
	a_ovr_needs_level: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!over_range_i |=> !ovr_expired) else $error("over-range expired without level");
	// count modes flag at the limit
	a_cnt_flag_limit: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(cmp_mode == CMP_CNT_CLR || cmp_mode == CMP_CNT_DEC) && res_valid_i && hit
		&& hits_r + 8'h01 == tlim_r |=> sta_r[STA_CMP_BIT])
		else $error("count limit not flagged");
	a_hits_step_up: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(cmp_mode == CMP_CNT_CLR || cmp_mode == CMP_CNT_DEC) && res_valid_i && hit
		&& hits_r < tlim_r |=> hits_r == $past(hits_r) + 8'h01)
		else $error("hit counter not incremented");
	a_conv_held: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cfg_r[CFG_RCNT_EN_BIT] && res_valid_i && rcnt_r + 16'h0001 < rlim_r
		&& !sta_r[STA_CONV_BIT] |=> !sta_r[STA_CONV_BIT])
		else $error("conversion flag not held off");
	a_vt_latest: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		vt_valid_i |=> vt_r == $past(vt_data_i)) else $error("latest v/t result lost");

	c_acc_clamp: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		acc_mode == ACC_CLAMP && res_valid_i && res_s < 0);
	c_cnt_limit: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cmp_mode == CMP_CNT_DEC && sta_nxt[STA_CMP_BIT] && !sta_r[STA_CMP_BIT]);
	c_ovr_set: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i) ovr_expired);
	c_rcnt_wrap: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cfg_r[CFG_RCNT_EN_BIT] && res_valid_i && rcnt_nxt == 16'h0000);
	c_cnt_clr_limit: cover property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		cmp_mode == CMP_CNT_CLR && sta_nxt[STA_CMP_BIT] && !sta_r[STA_CMP_BIT]);
endmodule
`default_nettype wire

// File: core/ccrm_pkg.sv
// package of constants for the current channel result monitor
package ccrm_pkg;
	// register offsets (plain port, word index)
	localparam logic [3:0] OFS_CONFIG      = 4'h0;
	localparam logic [3:0] OFS_STATUS      = 4'h1;
	localparam logic [3:0] OFS_ACC         = 4'h2;
	localparam logic [3:0] OFS_THRESHOLD   = 4'h3;
	localparam logic [3:0] OFS_THR_LIMIT   = 4'h4;
	localparam logic [3:0] OFS_THR_COUNT   = 4'h5;
	localparam logic [3:0] OFS_RES_LIMIT   = 4'h6;
	localparam logic [3:0] OFS_RES_COUNT   = 4'h7;
	localparam logic [3:0] OFS_VT_RESULT   = 4'h8;
	// config field positions
	localparam int CFG_RCNT_EN_BIT = 0;
	localparam int CFG_OVR_EN_BIT  = 2;
	localparam int CFG_CMP_LO      = 3;
	localparam int CFG_ACC_LO      = 5;
	localparam int CFG_GND_SW_BIT  = 7;
	// status field positions
	localparam int STA_CONV_BIT = 0;
	localparam int STA_CMP_BIT  = 1;
	localparam int STA_OVR_BIT  = 2;
	localparam int STA_VT_BIT   = 3;
	// reset values
	localparam logic [7:0]  CONFIG_RST    = 8'h00;
	localparam logic [15:0] RES_LIMIT_RST = 16'h0001;
	localparam logic [15:0] THRESHOLD_RST = 16'h0000;
	localparam logic [7:0]  THR_LIMIT_RST = 8'h01;
	// mode encodings
	localparam logic [1:0] ACC_OFF     = 2'b00;
	localparam logic [1:0] ACC_CLAMP   = 2'b01;
	localparam logic [1:0] ACC_SIGNED  = 2'b10;
	localparam logic [1:0] CMP_OFF     = 2'b00;
	localparam logic [1:0] CMP_PLAIN   = 2'b01;
	localparam logic [1:0] CMP_CNT_CLR = 2'b10;
	localparam logic [1:0] CMP_CNT_DEC = 2'b11;
	// over-range timing
	localparam int CLK_HZ       = 10_000_000;
	localparam int OVR_TIME_US  = 125;
	localparam int OVR_CYCLES   = (OVR_TIME_US * (CLK_HZ / 1_000_000));
endpackage

// File: core/ccrm_persist.sv
`timescale 1ns/10ps
`default_nettype none
// persistence timer: flags a level that has stood longer than a cycle count
module ccrm_persist #(
	parameter int CYCLES = 1250
) (
	input  wire logic clk_sys_i,
	input  wire logic arst_n_i,
	input  wire logic enable_i,
	input  wire logic level_i,
	output logic      expired_o
);
	localparam int W = $clog2(CYCLES + 2);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// count while the level stands, saturate past the limit
	always_comb begin
		cnt_nxt = cnt_r;
		if (!enable_i || !level_i) begin
			cnt_nxt = '0;
		end else if (cnt_r <= W'(CYCLES)) begin
			cnt_nxt = cnt_r + W'(1);
		end
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// strictly longer than the limit
	assign expired_o = (cnt_r > W'(CYCLES));
endmodule
`default_nettype wire

// File: verification/ccrm_adc_model.sv
// behavioural model of the current adc result source
`timescale 1ns/10ps
`default_nettype none
module ccrm_adc_model (
	input  wire logic        clk_sys_i,
	output logic             res_valid_o,
	output logic [15:0]      res_data_o,
	output logic             over_range_o
);
	// idle outputs at time zero
	initial begin
		res_valid_o = 1'b0;
		res_data_o = 16'h5a5a;
		over_range_o = 1'b0;
	end
	// one result strobe; data inverted once the strobe ends
	task automatic send(input logic [15:0] d);
		@(posedge clk_sys_i);
		res_valid_o <= 1'b1;
		res_data_o <= d;
		@(posedge clk_sys_i);
		res_valid_o <= 1'b0;
		res_data_o <= ~d;
	endtask
	// coarse over-range level held for n cycles
	task automatic over(input int n);
		@(posedge clk_sys_i);
		over_range_o <= 1'b1;
		repeat (n) @(posedge clk_sys_i);
		over_range_o <= 1'b0;
	endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// self-checking bench for the current channel result monitor
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ccrm_pkg::*;
	localparam logic [31:0] M = 32'hffffffff;
	logic        clk_sys_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic        res_valid, over_range, gnd_sw, irq;
	logic [15:0] res_data;
	logic        vt_valid = 1'b0;
	logic [15:0] vt_data = 16'h0000;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cyc = 0;
	// clock, 100 ns period
	always #50 clk_sys_i = ~clk_sys_i;
	ccrm_adc_model ccrm_adc_model_i (.clk_sys_i(clk_sys_i), .res_valid_o(res_valid),
		.res_data_o(res_data), .over_range_o(over_range));
	ccrm_monitor #(.OVR_CYC(8)) ccrm_monitor_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.res_valid_i(res_valid), .res_data_i(res_data), .over_range_i(over_range),
		.vt_valid_i(vt_valid), .vt_data_i(vt_data), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .gnd_switch_o(gnd_sw), .irq_o(irq));
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// one-cycle register write
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys_i);
		reg_wr <= 1'b0;
	endtask
	// read, then compare the masked word in the answer cycle
	task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e,
		input string n);
		@(posedge clk_sys_i);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys_i);
		reg_rd <= 1'b0;
		@(negedge clk_sys_i);
		chk(n, e, reg_rdata & m);
	endtask
	task automatic s(input logic [15:0] d);
		ccrm_adc_model_i.send(d);
	endtask
	// voltage/temperature result strobe
	task automatic vt(input logic [15:0] d);
		@(posedge clk_sys_i);
		vt_valid <= 1'b1;
		vt_data <= d;
		@(posedge clk_sys_i);
		vt_valid <= 1'b0;
		vt_data <= ~d;
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// hang guard
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fail_count++;
			print_verdict();
		end
	end
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		rdc(OFS_CONFIG, M, 32'h0, "config");
		rdc(OFS_THRESHOLD, M, 32'h0, "threshold");
		rdc(OFS_THR_LIMIT, M, 32'h1, "thr_limit");
		rdc(OFS_RES_LIMIT, M, 32'h1, "res_limit");
		rdc(4'hf, M, 32'h0, "unmapped");
		s(16'h0100);
		rdc(OFS_ACC, M, 32'h0, "acc_off");
		wr(OFS_CONFIG, 32'h20);
		s(16'h0005);
		s(16'hfffd);
		s(16'hfff6);
		rdc(OFS_ACC, M, 32'h0, "acc_clamp");
		s(16'h0007);
		rdc(OFS_ACC, M, 32'h7, "acc_add");
		wr(OFS_CONFIG, 32'h0);
		rdc(OFS_ACC, M, 32'h0, "acc_clear");
		wr(OFS_CONFIG, 32'h40);
		s(16'h0004);
		s(16'hfff6);
		s(16'h8000);
		rdc(OFS_ACC, M, 32'hffff7ffa, "acc_signed");
		wr(OFS_CONFIG, 32'h0);
		wr(OFS_THRESHOLD, 32'h64);
		wr(OFS_STATUS, 32'hf);
		s(16'h7fff);
		rdc(OFS_STATUS, 32'h2, 32'h0, "cmp_off");
		wr(OFS_CONFIG, 32'h08);
		s(16'h0063);
		rdc(OFS_STATUS, 32'h2, 32'h0, "cmp_below");
		s(16'hff9c);
		rdc(OFS_STATUS, 32'h2, 32'h2, "cmp_hit");
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFS_STATUS, 32'h2);
		wr(OFS_THR_LIMIT, 32'h3);
		wr(OFS_CONFIG, 32'h10);
		s(16'h0064);
		s(16'hff9b);
		rdc(OFS_THR_COUNT, M, 32'h2, "hits_up");
		s(16'h0032);
		rdc(OFS_THR_COUNT, M, 32'h0, "hits_clr");
		s(16'h0064);
		s(16'h0064);
		rdc(OFS_STATUS, 32'h2, 32'h0, "cmp_early");
		s(16'h0064);
		rdc(OFS_STATUS, 32'h2, 32'h2, "cmp_limit");
		wr(OFS_CONFIG, 32'h0);
		s(16'h0000);
		wr(OFS_STATUS, 32'hf);
		wr(OFS_CONFIG, 32'h18);
		s(16'h0064);
		s(16'h0064);
		s(16'h0032);
		rdc(OFS_THR_COUNT, M, 32'h1, "hits_dec");
		s(16'h0032);
		s(16'h0032);
		rdc(OFS_THR_COUNT, M, 32'h0, "hits_floor");
		wr(OFS_CONFIG, 32'h01);
		wr(OFS_RES_LIMIT, 32'h3);
		wr(OFS_STATUS, 32'hf);
		s(16'h0001);
		s(16'h0001);
		rdc(OFS_STATUS, 32'h1, 32'h0, "conv_held");
		rdc(OFS_RES_COUNT, M, 32'h2, "res_count");
		s(16'h0001);
		rdc(OFS_STATUS, 32'h1, 32'h1, "conv_limit");
		rdc(OFS_RES_COUNT, M, 32'h0, "res_wrap");
		s(16'h0001);
		rdc(OFS_RES_COUNT, M, 32'h1, "res_again");
		wr(OFS_RES_COUNT, 32'h5);
		rdc(OFS_RES_COUNT, M, 32'h1, "res_read_only");
		wr(OFS_CONFIG, 32'h04);
		wr(OFS_STATUS, 32'hf);
		@(negedge clk_sys_i);
		chk("irq_idle", 32'h0, {31'h0, irq});
		ccrm_adc_model_i.over(6);
		rdc(OFS_STATUS, 32'h4, 32'h0, "ovr_short");
		ccrm_adc_model_i.over(14);
		rdc(OFS_STATUS, 32'h4, 32'h4, "ovr_long");
		vt(16'h1234);
		vt(16'hbeef);
		rdc(OFS_VT_RESULT, M, 32'hbeef, "vt_latest");
		rdc(OFS_STATUS, 32'h8, 32'h8, "vt_flag");
		wr(OFS_CONFIG, 32'h80);
		@(negedge clk_sys_i);
		chk("gnd_switch", 32'h1, {31'h0, gnd_sw});
		// reset again in mid-run, then look at the reset state
		@(posedge clk_sys_i);
		arst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		@(negedge clk_sys_i);
		chk("irq_rst", 32'h0, {31'h0, irq});
		chk("gnd_switch_rst", 32'h0, {31'h0, gnd_sw});
		rdc(OFS_CONFIG, M, 32'h0, "config_rst");
		rdc(OFS_VT_RESULT, M, 32'h0, "vt_rst");
		rdc(OFS_RES_LIMIT, M, 32'h1, "res_limit_rst");
		print_verdict();
	end
endmodule
`default_nettype wire
